// ### core/udrt_params.svh
// Register offsets, field positions, reset values and count limits of the timer
`ifndef UDRT_PARAMS_SVH
`define UDRT_PARAMS_SVH

// ----------------------------------------
// Register word indexes; byte address is index times four
// ----------------------------------------
`define UDRT_OFF_CONTROL   3'd0
`define UDRT_OFF_MODE      3'd1
`define UDRT_OFF_CNT_LOW   3'd2
`define UDRT_OFF_CNT_HIGH  3'd3
`define UDRT_OFF_RLD_LOW   3'd4
`define UDRT_OFF_RLD_HIGH  3'd5
`define UDRT_OFF_CONFIG    3'd6

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define UDRT_CTL_OVF       7
`define UDRT_CTL_EXT       6
`define UDRT_CTL_RCLK      5
`define UDRT_CTL_TRANSMIT_CLOCK_SELECT      4
`define UDRT_CTL_EXEN      3
`define UDRT_CTL_RUN       2
`define UDRT_CTL_CT        1
`define UDRT_CTL_CPRL      0

// ----------------------------------------
// Mode and config register fields
// ----------------------------------------
`define UDRT_MODE_OE       1
`define UDRT_MODE_DOWN_COUNT_ENABLE     0
`define UDRT_CFG_SIX       0
`define UDRT_CFG_IRQEN     1

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define UDRT_CONTROL_RST   8'h00
`define UDRT_MODE_RST      8'h00
`define UDRT_CNT_MAX       16'hffff
`define UDRT_DIV_TIMER6    4'd6
`define UDRT_DIV_TIMER12   4'd12
`define UDRT_DIV_BAUD6     4'd1
`define UDRT_DIV_BAUD12    4'd2
`define UDRT_BAUD_DIV_LAST 4'hf

`endif

// ### core/udrt_pkg.sv
// Types shared by the timer and its users
package udrt_pkg;

    // ----------------------------------------
    // Operating modes, Gray coded
    // ----------------------------------------
    typedef enum logic [1:0] {
        UDRT_OFF  = 2'b00,
        UDRT_AUTO = 2'b01,
        UDRT_CAPT = 2'b11,
        UDRT_BAUD = 2'b10
    } udrt_mode_e;

    // ----------------------------------------
    // Serial bit clocks handed to the port
    // ----------------------------------------
    typedef struct packed {
        logic tx_tick;
        logic rx_tick;
    } udrt_baud_s;

    // ----------------------------------------
    // Whole state of the timer
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]  ctl;
        logic [7:0]  mode;
        logic [1:0]  cfg;
        logic [15:0] cnt;
        logic [15:0] rld;
        logic [3:0]  presc;
        logic        trg_m;
        logic        trg_s;
        logic        trg_p;
        logic        pin_m;
        logic        pin_s;
        logic        pin_p;
        logic [3:0]  tx_div;
        logic [3:0]  rx_div;
        udrt_baud_s  baud;
        logic        irq;
        logic        wr_pend;
        logic [2:0]  widx;
        logic [31:0] hrdata;
        logic        hready;
    } udrt_state_s;

endpackage : udrt_pkg

// ### core/udrt_timer.sv
// Sixteen-bit up/down auto-reload timer with baud generation, AHB-Lite register slave
//
// Operation
// - Down-count enable resets to zero; timer counts up only until software sets it.
// - Up-only, external enable clear: count to FFFF, set overflow, reload from reload pair.
// - Up-only, external enable set: trigger falling edge reloads and sets external flag.
// - Auto-reload interrupt request when enabled and overflow flag is one, or external flag without direction control.
// - Direction control, trigger high: count up, overflow at FFFF, set flag, reload.
// - Direction control, trigger low: count down, underflow at reload, load FFFF.
// - Direction control: external flag toggles on each wrap, never requests interrupt.
// - Transmit-clock select one takes transmit bit clock from this timer, else other.
// - Receive-clock select picks the receive bit clock source the same way.
// - Baud mode: high byte rollover reloads counter from reload pair.
// - Serial bit rate equals selected overflow rate divided by sixteen.
// - Plain timer increments every machine cycle: osc/6 or osc/12.
// - Internal baud clocking increments at osc (6-clock) or osc/2 (12-clock).
// - Internal baud bit rate is osc over n times (65536 minus reload).
// - Baud mode rollover sets no overflow flag and requests no interrupt.
// - Baud mode trigger falling edge sets external flag but does not reload.
// - Control bits MSB to LSB: ovf, ext, rclk, transmit_clock_select, exen, run, c/t, cp/rl.
`timescale 1ns/1ps
`include "udrt_params.svh"

module udrt_timer (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic               count_input_pin,
    input  wire logic               trigger_direction_pin,
    input  wire logic               other_timer_overflow,
    output udrt_pkg::udrt_baud_s    baud_ticks,
    output logic                    timer_irq
);
    import udrt_pkg::*;

    udrt_state_s q;
    udrt_state_s d;
    udrt_mode_e  mode;
    logic        dir_ctl;
    logic        step;
    logic        tick;
    logic        own_ovf;
    logic        ovf_set;
    logic        ext_set;
    logic        ext_tog;
    logic        trg_fall;
    logic        pin_fall;
    logic        tx_src;
    logic        rx_src;
    logic        addr_ok;
    logic [3:0]  lim;
    logic [2:0]  ridx;

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    always_comb begin
        if (!q.ctl[`UDRT_CTL_RUN]) begin
            mode = UDRT_OFF;
        end else if (q.ctl[`UDRT_CTL_RCLK] | q.ctl[`UDRT_CTL_TRANSMIT_CLOCK_SELECT]) begin
            mode = UDRT_BAUD;
        end else if (q.ctl[`UDRT_CTL_CPRL]) begin
            mode = UDRT_CAPT;
        end else begin
            mode = UDRT_AUTO;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        d        = q;
        tick     = 1'b0;
        step     = 1'b0;
        own_ovf  = 1'b0;
        ovf_set  = 1'b0;
        ext_set  = 1'b0;
        ext_tog  = 1'b0;
        dir_ctl  = 1'b0;
        tx_src   = 1'b0;
        rx_src   = 1'b0;
        addr_ok  = 1'b0;
        ridx     = 3'd0;
        lim      = `UDRT_DIV_TIMER12;

        // Pin synchronisers and edge detect
        d.trg_m  = trigger_direction_pin;
        d.trg_s  = q.trg_m;
        d.trg_p  = q.trg_s;
        d.pin_m  = count_input_pin;
        d.pin_s  = q.pin_m;
        d.pin_p  = q.pin_s;
        trg_fall = q.trg_p & ~q.trg_s;
        pin_fall = q.pin_p & ~q.pin_s;

        // Prescaler
        if (mode == UDRT_BAUD) begin
            lim = q.cfg[`UDRT_CFG_SIX] ? `UDRT_DIV_BAUD6 : `UDRT_DIV_BAUD12;
        end else begin
            lim = q.cfg[`UDRT_CFG_SIX] ? `UDRT_DIV_TIMER6 : `UDRT_DIV_TIMER12;
        end
        if (mode == UDRT_OFF) begin
            d.presc = 4'd0;
        end else if (q.presc >= lim - 4'd1) begin
            d.presc = 4'd0;
            tick    = 1'b1;
        end else begin
            d.presc = q.presc + 4'd1;
        end
        step = (mode != UDRT_OFF) & (q.ctl[`UDRT_CTL_CT] ? pin_fall : tick);

        // Counting
        unique case (mode)
            UDRT_OFF: begin
            end
            UDRT_AUTO: begin
                dir_ctl = q.mode[`UDRT_MODE_DOWN_COUNT_ENABLE];
                if (step && dir_ctl && !q.trg_s) begin
                    if (q.cnt == q.rld) begin
                        d.cnt   = `UDRT_CNT_MAX;
                        ovf_set = 1'b1;
                        ext_tog = 1'b1;
                    end else begin
                        d.cnt = q.cnt - 16'd1;
                    end
                end else if (step && q.cnt == `UDRT_CNT_MAX) begin
                    d.cnt   = q.rld;
                    ovf_set = 1'b1;
                    ext_tog = dir_ctl;
                    own_ovf = 1'b1;
                end else if (step) begin
                    d.cnt = q.cnt + 16'd1;
                end
                if (!dir_ctl && q.ctl[`UDRT_CTL_EXEN] && trg_fall) begin
                    d.cnt   = q.rld;
                    ext_set = 1'b1;
                end
            end
            UDRT_CAPT: begin
                if (step) begin
                    d.cnt   = q.cnt + 16'd1;
                    ovf_set = (q.cnt == `UDRT_CNT_MAX);
                    own_ovf = ovf_set;
                end
                ext_set = q.ctl[`UDRT_CTL_EXEN] & trg_fall;
            end
            UDRT_BAUD: begin
                if (step && q.cnt == `UDRT_CNT_MAX) begin
                    d.cnt   = q.rld;
                    own_ovf = 1'b1;
                end else if (step) begin
                    d.cnt = q.cnt + 16'd1;
                end
                ext_set = q.ctl[`UDRT_CTL_EXEN] & trg_fall;
            end
        endcase

        // Serial bit clocks
        tx_src = q.ctl[`UDRT_CTL_TRANSMIT_CLOCK_SELECT] ? own_ovf : other_timer_overflow;
        rx_src = q.ctl[`UDRT_CTL_RCLK] ? own_ovf : other_timer_overflow;
        d.baud.tx_tick = tx_src & (q.tx_div == `UDRT_BAUD_DIV_LAST);
        d.baud.rx_tick = rx_src & (q.rx_div == `UDRT_BAUD_DIV_LAST);
        if (tx_src) begin
            d.tx_div = q.tx_div + 4'd1;
        end
        if (rx_src) begin
            d.rx_div = q.rx_div + 4'd1;
        end

        // Bus write, data phase
        if (q.wr_pend) begin
            unique case (q.widx)
                `UDRT_OFF_CONTROL:  d.ctl      = hwdata[7:0];
                `UDRT_OFF_MODE:     d.mode     = {6'h00, hwdata[1:0]};
                `UDRT_OFF_CNT_LOW:  d.cnt[7:0]  = hwdata[7:0];
                `UDRT_OFF_CNT_HIGH: d.cnt[15:8] = hwdata[7:0];
                `UDRT_OFF_RLD_LOW:  d.rld[7:0]  = hwdata[7:0];
                `UDRT_OFF_RLD_HIGH: d.rld[15:8] = hwdata[7:0];
                `UDRT_OFF_CONFIG:   d.cfg      = hwdata[1:0];
                default: begin
                end
            endcase
        end

        // Flag events win over a clearing write
        d.ctl[`UDRT_CTL_OVF] = d.ctl[`UDRT_CTL_OVF] | ovf_set;
        d.ctl[`UDRT_CTL_EXT] = (d.ctl[`UDRT_CTL_EXT] | ext_set) ^ ext_tog;

        // Interrupt request
        d.irq = q.cfg[`UDRT_CFG_IRQEN] & (d.ctl[`UDRT_CTL_OVF]
                | (d.ctl[`UDRT_CTL_EXT] & ~dir_ctl));

        // Bus address phase
        d.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            addr_ok = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'b00)
                      && (haddr[4:2] != 3'd7);
            ridx    = haddr[4:2];
            d.wr_pend = hwrite & addr_ok;
            d.widx    = ridx;
            d.hrdata  = 32'h0000_0000;
            if (!hwrite && addr_ok) begin
                unique case (ridx)
                    `UDRT_OFF_CONTROL:  d.hrdata[7:0] = d.ctl;
                    `UDRT_OFF_MODE:     d.hrdata[7:0] = d.mode;
                    `UDRT_OFF_CNT_LOW:  d.hrdata[7:0] = d.cnt[7:0];
                    `UDRT_OFF_CNT_HIGH: d.hrdata[7:0] = d.cnt[15:8];
                    `UDRT_OFF_RLD_LOW:  d.hrdata[7:0] = d.rld[7:0];
                    `UDRT_OFF_RLD_HIGH: d.hrdata[7:0] = d.rld[15:8];
                    `UDRT_OFF_CONFIG:   d.hrdata[1:0] = d.cfg;
                    default: begin
                    end
                endcase
            end
        end
        d.hready = 1'b1;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q        <= '0;
            q.hready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign hrdata     = q.hrdata;
    assign hreadyout  = q.hready;
    assign hresp      = q.ctl[`UDRT_CTL_RUN] & 1'b0;
    assign baud_ticks = q.baud;
    assign timer_irq  = q.irq;

endmodule : udrt_timer

// ### tb/tb_top.sv
// Self-checking bench for the up/down reload timer
`timescale 1ns/1ps
module tb_top;
    import udrt_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        cin;
    logic        trg;
    logic        oth;
    logic        irq;
    udrt_baud_s  ticks;
    int          tx_cnt;
    int          rx_cnt;
    int          error_cnt;
    int          checks_done;
    logic [31:0] rv;
    udrt_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .count_input_pin(cin), .trigger_direction_pin(trg), .other_timer_overflow(oth),
        .baud_ticks(ticks), .timer_irq(irq));
    udrt_serial_model #(.OTHER_PERIOD(10)) u_ser (.hclk(hclk), .hresetn(hresetn),
        .baud_ticks(ticks), .other_timer_overflow(oth), .tx_cnt(tx_cnt), .rx_cnt(rx_cnt));
    always #25 hclk = ~hclk;
    // ----------------------------------------
    // Bus cycles and comparison
    // ----------------------------------------
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        check(rv[15:0], {8'h00, e});
    endtask : rd_chk
    task automatic wait_irq();
        for (int n = 0; n < 400 && irq !== 1'b1; n++)
            @(posedge hclk);
        check({15'h0000, irq}, 16'h0001);
    endtask : wait_irq
    task automatic test_reset();
        for (int i = 0; i < 8; i++)
            rd_chk(8'(i * 4), 8'h00);
        wr(8'h1C, 8'hFF);
        rd_chk(8'h1C, 8'h00);
        check({15'h0000, hresp}, 16'h0000);
        check({15'h0000, hreadyout}, 16'h0001);
        $display("test reset done");
    endtask : test_reset
    task automatic test_rate();
        logic [7:0] cf [4] = '{8'h03, 8'h02, 8'h03, 8'h02};
        logic [7:0] ct [4] = '{8'h04, 8'h04, 8'h14, 8'h14};
        logic [7:0] ex [4] = '{8'h0A, 8'h05, 8'h3D, 8'h1E};
        for (int i = 0; i < 4; i++) begin
            wr(8'h18, cf[i]);
            wr(8'h08, 8'h00);
            wr(8'h0C, 8'h00);
            wr(8'h00, ct[i] & 8'hFB);
            wr(8'h00, ct[i]);
            repeat (59) @(posedge hclk);
            wr(8'h00, 8'h00);
            rd_chk(8'h08, ex[i]);
        end
        $display("test rate done");
    endtask : test_rate
    task automatic test_trigger();
        wr(8'h18, 8'h02);
        wr(8'h10, 8'hCD);
        wr(8'h14, 8'hAB);
        wr(8'h08, 8'h34);
        wr(8'h0C, 8'h12);
        wr(8'h00, 8'h08);
        wr(8'h00, 8'h0C);
        trg <= 1'b0;
        wait_irq();
        rd_chk(8'h00, 8'h4C);
        trg <= 1'b1;
        wr(8'h00, 8'h00);
        rd_chk(8'h0C, 8'hAB);
        wr(8'h08, 8'h00);
        wr(8'h0C, 8'h00);
        wr(8'h00, 8'h1C);
        trg <= 1'b0;
        repeat (10) @(posedge hclk);
        rd_chk(8'h00, 8'h5C);
        wr(8'h00, 8'h00);
        rd_chk(8'h0C, 8'h00);
        trg <= 1'b1;
        $display("test trigger done");
    endtask : test_trigger
    task automatic test_updown();
        wr(8'h01 * 4, 8'h01);
        trg <= 1'b0;
        wr(8'h14, 8'h01);
        wr(8'h10, 8'h00);
        wr(8'h0C, 8'h01);
        wr(8'h08, 8'h02);
        wr(8'h00, 8'h04);
        wait_irq();
        rd_chk(8'h00, 8'hC4);
        wr(8'h00, 8'h00);
        rd_chk(8'h08, 8'hFF);
        rd_chk(8'h0C, 8'hFF);
        trg <= 1'b1;
        wr(8'h08, 8'hFE);
        wr(8'h14, 8'h55);
        wr(8'h10, 8'h55);
        wr(8'h00, 8'h04);
        wait_irq();
        rd_chk(8'h00, 8'hC4);
        wr(8'h00, 8'h44);
        repeat (3) @(posedge hclk);
        check({15'h0000, irq}, 16'h0000);
        wr(8'h00, 8'h00);
        rd_chk(8'h0C, 8'h55);
        wr(8'h04, 8'h00);
        $display("test updown done");
    endtask : test_updown
    task automatic test_baud();
        logic [7:0] c [2] = '{8'h24, 8'h14};
        int t0;
        int r0;
        wr(8'h18, 8'h03);
        wr(8'h14, 8'hFF);
        wr(8'h10, 8'hFC);
        wr(8'h08, 8'hFC);
        wr(8'h0C, 8'hFF);
        for (int i = 0; i < 2; i++) begin
            wr(8'h00, c[i]);
            repeat (20) @(posedge hclk);
            t0 = tx_cnt;
            r0 = rx_cnt;
            repeat (640) @(posedge hclk);
            check(16'(tx_cnt - t0), c[i][4] ? 16'h000A : 16'h0004);
            check(16'(rx_cnt - r0), c[i][5] ? 16'h000A : 16'h0004);
        end
        wr(8'h00, 8'h10);
        repeat (20) @(posedge hclk);
        wr(8'h00, 8'h00);
        $display("test baud done");
    endtask : test_baud
    task automatic test_count();
        wr(8'h08, 8'h00);
        wr(8'h0C, 8'h00);
        wr(8'h00, 8'h02);
        wr(8'h00, 8'h06);
        for (int i = 0; i < 3; i++) begin
            cin <= 1'b0;
            repeat (4) @(posedge hclk);
            cin <= 1'b1;
            repeat (4) @(posedge hclk);
        end
        wr(8'h00, 8'h00);
        rd_chk(8'h08, 8'h03);
        wr(8'h08, 8'hFF);
        wr(8'h0C, 8'hFF);
        wr(8'h00, 8'h01);
        wr(8'h00, 8'h05);
        repeat (10) @(posedge hclk);
        rd_chk(8'h00, 8'h85);
        wr(8'h00, 8'h00);
        rd_chk(8'h0C, 8'h00);
        $display("test count done");
    endtask : test_count
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        trg = 1'b1;
        cin = 1'b1;
        error_cnt = 0;
        checks_done = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset();
        test_rate();
        test_trigger();
        test_updown();
        test_baud();
        test_count();
        give_verdict();
    end
    initial begin
        #1_000_000;
        error_cnt++;
        give_verdict();
    end
endmodule : tb_top

// ### tb/udrt_serial_model.sv
// Serial port end: counts bit clocks, supplies the other timer's overflow
`timescale 1ns/1ps
module udrt_serial_model #(
    parameter int OTHER_PERIOD = 10
) (
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire udrt_pkg::udrt_baud_s baud_ticks,
    output logic                    other_timer_overflow,
    output int                      tx_cnt,
    output int                      rx_cnt
);
    import udrt_pkg::*;
    int div_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 0;
            other_timer_overflow <= 1'b0;
            tx_cnt <= 0;
            rx_cnt <= 0;
        end else begin
            div_q <= (div_q == OTHER_PERIOD - 1) ? 0 : div_q + 1;
            other_timer_overflow <= (div_q == OTHER_PERIOD - 1);
            tx_cnt <= tx_cnt + int'(baud_ticks.tx_tick === 1'b1);
            rx_cnt <= rx_cnt + int'(baud_ticks.rx_tick === 1'b1);
        end
    end
endmodule : udrt_serial_model

// ### tb/udrt_sva.sv
// Port-level checks of the timer, bound into every instance
`timescale 1ns/1ps
module udrt_sva (
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    input wire logic [31:0]         hrdata,
    input wire logic                trigger_direction_pin,
    input wire logic                other_timer_overflow,
    input wire udrt_pkg::udrt_baud_s baud_ticks,
    input wire logic                timer_irq
);
    import udrt_pkg::*;
    // ----------------------------------------
    // Shadow of software writes
    // ----------------------------------------
    logic [7:0] reg_q [0:7];
    logic [2:0] idx_q;
    logic       wr_q;
    logic [7:0] ctl;
    logic       auto_ext;
    logic       quiet;
    assign ctl = reg_q[0];
    assign auto_ext = ctl[2] && ctl[3] && ctl[5:4] == 2'b00 && !ctl[0] && !reg_q[1][0]
                      && reg_q[6][1];
    assign quiet = ctl[2] && ctl[5:4] != 2'b00 && ctl[7:6] == 2'b00 && !ctl[3];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            idx_q <= 3'd0;
            for (int i = 0; i < 8; i++) reg_q[i] <= 8'h00;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite && haddr[31:5] == 27'h000_0000;
            idx_q <= haddr[4:2];
            if (wr_q) reg_q[idx_q] <= hwdata[7:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_at(logic [31:0] a);
        hsel && hready && htrans[1] && !hwrite && haddr == a ##1 1'b1;
    endsequence
    sequence irq_soon;
        ##[2:8] timer_irq;
    endsequence
    mode_rsvd_a: assert property (rd_at(32'h0000_0004) |-> hrdata[31:2] == 30'h0)
        else $error("mode reserved bits not zero");
    ctl_width_a: assert property (rd_at(32'h0000_0000) |-> hrdata[31:8] == 24'h00_0000)
        else $error("control wider than eight bits");
    tx_source_a: assert property (baud_ticks.tx_tick && !ctl[4] && !$past(ctl[4], 3)
        |-> $past(other_timer_overflow) || $past(other_timer_overflow, 2))
        else $error("tx tick without other timer overflow");
    rx_source_a: assert property (baud_ticks.rx_tick && !ctl[5] && !$past(ctl[5], 3)
        |-> $past(other_timer_overflow) || $past(other_timer_overflow, 2))
        else $error("rx tick without other timer overflow");
    trig_irq_a: assert property ($fell(trigger_direction_pin) && auto_ext |-> irq_soon)
        else $error("trigger edge raised no request");
    baud_quiet_a: assert property (quiet && $past(quiet) && $past(quiet, 2)
        && $past(quiet, 3) |-> !timer_irq)
        else $error("request in baud mode");
    irq_hold_a: assert property ($fell(timer_irq)
        |-> $past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3))
        else $error("request dropped without a write");
    stop_quiet_a: assert property (!ctl[2] && !$past(ctl[2], 3) && ctl[4]
        && $past(ctl[4], 3) |-> !baud_ticks.tx_tick)
        else $error("tick while stopped");
endmodule : udrt_sva
bind udrt_timer udrt_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .trigger_direction_pin(trigger_direction_pin), .other_timer_overflow(other_timer_overflow),
    .baud_ticks(baud_ticks), .timer_irq(timer_irq));
